// ===== logic/pmt_timer.sv
// file: period match timer with prescaler, postscaler and APB registers
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pmt_timer (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // events
  output logic o_period_match,
  output logic o_irq
);
  import pmt_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] count;
    logic [7:0] period;
    logic [7:0] status;
    logic [7:0] mask;
    logic [1:0] iclk;
    logic [3:0] pre;
    logic [3:0] post;
    logic match;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pmt_state_t;

  pmt_state_t s_q;
  pmt_state_t s_d;

  // ==========================================================
  // next state
  always_comb begin
    logic wr;
    logic rd;
    logic tick;
    logic pre_done;
    logic hit;
    logic post_fire;
    logic [3:0] pre_last;
    logic [7:0] wb;
    logic hold;
    wr = 1'b0;
    rd = 1'b0;
    tick = 1'b0;
    pre_done = 1'b0;
    hit = 1'b0;
    post_fire = 1'b0;
    pre_last = PMT_PRE_LAST16;
    wb = i_pwdata[7:0];
    hold = 1'b0;
    s_d = s_q;
    s_d.match = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    // one cycle access phase wait, answer on the next edge
    wr = i_psel && i_penable && !s_q.pready && i_pwrite;
    rd = i_psel && i_penable && !s_q.pready && !i_pwrite;
    // control or count write freezes the step, so no stray match or flag
    hold = wr && (i_paddr == PMT_OFF_CONTROL || i_paddr == PMT_OFF_COUNT);
    // instruction clock divider
    if (s_q.ctrl[PMT_RUN_BIT]) begin
      s_d.iclk = s_q.iclk + 2'h1;
      tick = (s_q.iclk == PMT_ICLK_LAST);
    end
    // prescale select
    if (s_q.ctrl[PMT_PRE_LSB +: 2] == PMT_PRE_DIV1) begin
      pre_last = 4'h0;
    end else if (s_q.ctrl[PMT_PRE_LSB +: 2] == PMT_PRE_DIV4) begin
      pre_last = PMT_PRE_LAST4;
    end
    if (tick) begin
      pre_done = (s_q.pre >= pre_last);
      s_d.pre = pre_done ? 4'h0 : s_q.pre + 4'h1;
    end
    // counter step and wrap
    if (pre_done && !hold) begin
      hit = (s_q.count == s_q.period);
      s_d.count = hit ? PMT_RESET_BYTE : s_q.count + 8'h01;
    end
    // postscaler
    if (hit) begin
      s_d.match = 1'b1;
      post_fire = (s_q.post >= s_q.ctrl[PMT_POST_LSB +: 4]);
      s_d.post = post_fire ? 4'h0 : s_q.post + 4'h1;
    end
    // register writes
    if (wr) begin
      s_d.pready = 1'b1;
      if (i_paddr == PMT_OFF_CONTROL) begin
        s_d.ctrl = wb & PMT_CTRL_WMASK;
        s_d.pre = 4'h0; // counter kept
        s_d.post = 4'h0;
        s_d.iclk = 2'h0;
      end else if (i_paddr == PMT_OFF_COUNT) begin
        s_d.count = wb;
        s_d.pre = 4'h0;
        s_d.post = 4'h0;
        s_d.iclk = 2'h0;
      end else if (i_paddr == PMT_OFF_PERIOD) begin
        s_d.period = wb;
      end else if (i_paddr == PMT_OFF_STATUS) begin
        s_d.status = s_q.status & ~(wb & PMT_STAT_WMASK);
      end else if (i_paddr == PMT_OFF_MASK) begin
        s_d.mask = wb & PMT_STAT_WMASK;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
    // flag set wins over a clear in the same cycle
    if (post_fire) begin
      s_d.status[PMT_FLAG_BIT] = 1'b1;
    end
    // register reads
    if (rd) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      if (i_paddr == PMT_OFF_CONTROL) begin
        s_d.prdata[7:0] = s_q.ctrl & PMT_CTRL_WMASK;
      end else if (i_paddr == PMT_OFF_COUNT) begin
        s_d.prdata[7:0] = s_q.count;
      end else if (i_paddr == PMT_OFF_PERIOD) begin
        s_d.prdata[7:0] = s_q.period;
      end else if (i_paddr == PMT_OFF_STATUS) begin
        s_d.prdata[7:0] = s_q.status;
      end else if (i_paddr == PMT_OFF_MASK) begin
        s_d.prdata[7:0] = s_q.mask;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.period <= PMT_PERIOD_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_period_match = s_q.match;
  assign o_irq = s_q.irq;

  // ==========================================================
  // checks
  default clocking cb_chk @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  // bus accesses taken at this edge, by kind
  sequence seq_access;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence seq_count_write;
    i_psel && i_penable && !o_pready && i_pwrite && i_paddr == PMT_OFF_COUNT;
  endsequence
  sequence seq_ctrl_write;
    i_psel && i_penable && !o_pready && i_pwrite && i_paddr == PMT_OFF_CONTROL;
  endsequence
  sequence seq_period_write;
    i_psel && i_penable && !o_pready && i_pwrite && i_paddr == PMT_OFF_PERIOD;
  endsequence
  sequence seq_flag_clear;
    i_psel && i_penable && !o_pready && i_pwrite && i_paddr == PMT_OFF_STATUS
      && i_pwdata[PMT_FLAG_BIT];
  endsequence
  sequence seq_ctrl_read;
    i_psel && i_penable && !o_pready && !i_pwrite && i_paddr == PMT_OFF_CONTROL;
  endsequence
  sequence seq_count_read;
    i_psel && i_penable && !o_pready && !i_pwrite && i_paddr == PMT_OFF_COUNT;
  endsequence
  sequence seq_period_read;
    i_psel && i_penable && !o_pready && !i_pwrite && i_paddr == PMT_OFF_PERIOD;
  endsequence
  sequence seq_bad_addr;
    i_psel && i_penable && !o_pready && i_paddr != PMT_OFF_CONTROL
      && i_paddr != PMT_OFF_COUNT && i_paddr != PMT_OFF_PERIOD
      && i_paddr != PMT_OFF_STATUS && i_paddr != PMT_OFF_MASK;
  endsequence
  // answer shape and match spacing
  sequence seq_answer;
    o_pready ##1 !o_pready;
  endsequence
  sequence seq_quiet3;
    !o_period_match [*3];
  endsequence

  // counter clears on reset, checked through reset itself
  AST_CNT_RESET: assert property (disable iff (1'b0) i_sys_rst |=> s_q.count == 8'h00)
    else $error("counter not cleared by reset");
  // counter write lands and clears the prescaler
  AST_CNT_WRITE: assert property (
    seq_count_write |=> s_q.count == $past(i_pwdata[7:0]) && s_q.pre == 4'h0)
    else $error("counter write lost");
  // period write lands
  AST_PERIOD_WRITE: assert property (
    seq_period_write |=> s_q.period == $past(i_pwdata[7:0]))
    else $error("period write lost");
  // counter read returns the counter
  AST_READ_COUNT: assert property (
    seq_count_read |=> o_prdata[7:0] == $past(s_q.count))
    else $error("counter read wrong");
  // period read returns the period
  AST_READ_PERIOD: assert property (
    seq_period_read |=> o_prdata[7:0] == $past(s_q.period))
    else $error("period read wrong");
  // every access is answered after one wait state, for one cycle
  AST_READY: assert property (seq_access |=> seq_answer)
    else $error("access not answered in time");
  // unmapped address answers with an error
  AST_SLVERR: assert property (seq_bad_addr |=> o_pslverr && o_pready)
    else $error("unmapped access without error");

  // instruction clock divider steps while running
  AST_ICLK_STEP: assert property (
    s_q.ctrl[PMT_RUN_BIT] && !(seq_access && i_pwrite) |=> s_q.iclk == $past(s_q.iclk) + 2'h1)
    else $error("instruction clock divider stalled");
  // matches at least one instruction clock apart
  AST_DIV1: assert property (o_period_match |=> seq_quiet3)
    else $error("matches closer than the instruction clock");
  // divide by one keeps the prescaler at zero
  AST_PRE_DIV1: assert property (
    s_q.ctrl[PMT_PRE_LSB +: 2] == PMT_PRE_DIV1 |-> s_q.pre == 4'h0)
    else $error("prescaler moved at divide by one");
  // divide by four keeps the prescaler within four steps
  AST_PRE_DIV4: assert property (
    s_q.ctrl[PMT_PRE_LSB +: 2] == PMT_PRE_DIV4 |-> s_q.pre <= PMT_PRE_LAST4)
    else $error("prescaler beyond divide by four");
  // postscaler never passes its selected ratio
  AST_POST_BOUND: assert property (s_q.post <= s_q.ctrl[PMT_POST_LSB +: 4])
    else $error("postscaler beyond its ratio");

  // flag set at 1:1 postscale with every match
  AST_FLAG: assert property (
    (o_period_match && s_q.post == 4'h0 && $past(s_q.ctrl[PMT_POST_LSB +: 4]) == 4'h0)
    |-> s_q.status[PMT_FLAG_BIT])
    else $error("flag not set at 1:1 postscale");
  // flag only rises together with a match
  AST_FLAG_SOURCE: assert property ($rose(s_q.status[PMT_FLAG_BIT]) |-> o_period_match)
    else $error("flag set without a match");
  // flag stays until software clears it
  AST_FLAG_STICKY: assert property (
    s_q.status[PMT_FLAG_BIT] && !(seq_access && i_pwrite && i_paddr == PMT_OFF_STATUS
      && i_pwdata[PMT_FLAG_BIT]) |=> s_q.status[PMT_FLAG_BIT])
    else $error("flag lost without a clear");
  // writing one clears the flag unless a new match sets it
  AST_FLAG_CLEAR: assert property (
    seq_flag_clear |=> !s_q.status[PMT_FLAG_BIT] || o_period_match)
    else $error("flag not cleared by write");

  // a match comes from counter equal to period
  AST_MATCH_CAUSE: assert property (
    o_period_match |-> $past(s_q.count) == $past(s_q.period))
    else $error("match without equal count");
  // interrupt line follows status and mask
  AST_IRQ: assert property (o_irq == |(s_q.status & s_q.mask))
    else $error("irq does not follow status and mask");

  // no match unless the timer was running
  AST_MATCH_RUN: assert property (o_period_match |-> $past(s_q.ctrl[PMT_RUN_BIT]))
    else $error("match while timer off");
  // counter holds while off
  AST_HOLD_OFF: assert property (
    (!s_q.ctrl[PMT_RUN_BIT] && !(seq_access && i_pwrite && i_paddr == PMT_OFF_COUNT))
    |=> $stable(s_q.count))
    else $error("counter moved while off");

  // control write clears both scalers
  AST_CTRL_KEEP: assert property (
    seq_ctrl_write |=> s_q.pre == 4'h0 && s_q.post == 4'h0 && s_q.ctrl[7] == 1'b0)
    else $error("control write did not clear scalers");
  // counter write clears the postscaler and divider phase
  AST_POST_CLEAR: assert property (
    seq_count_write |=> s_q.post == 4'h0 && s_q.iclk == 2'h0)
    else $error("counter write did not clear postscaler");
  // control write leaves the counter alone
  AST_CTRL_CNT: assert property (seq_ctrl_write |=> s_q.count == $past(s_q.count))
    else $error("control write changed counter");

  // unimplemented control bit stays zero
  AST_BIT7: assert property (s_q.ctrl[7] == 1'b0)
    else $error("control bit 7 set");
  // control read shows bit 7 and the upper bits as zero
  AST_READ_CTRL: assert property (seq_ctrl_read |=> o_prdata[31:7] == '0)
    else $error("control read shows unimplemented bits");

  // time base event is a single cycle pulse
  AST_MATCH_PULSE: assert property (o_period_match |=> !o_period_match)
    else $error("match pulse too long");
  // counter wraps to zero on a match
  AST_WRAP: assert property (o_period_match |-> s_q.count == 8'h00)
    else $error("counter did not wrap on match");
  // counter only holds, steps by one or wraps
  AST_STEP: assert property (
    !(seq_access && i_pwrite && i_paddr == PMT_OFF_COUNT) |=> s_q.count == $past(s_q.count)
      || s_q.count == $past(s_q.count) + 8'h01 || o_period_match)
    else $error("counter jumped");
endmodule : pmt_timer
`default_nettype wire

// ===== logic/pmt_pkg.sv
// package: register map, field layout and timing constants of the period match timer
package pmt_pkg;
  // register byte offsets on the bus
  localparam logic [11:0] PMT_OFF_CONTROL = 12'h000;
  localparam logic [11:0] PMT_OFF_COUNT = 12'h004;
  localparam logic [11:0] PMT_OFF_PERIOD = 12'h008;
  localparam logic [11:0] PMT_OFF_STATUS = 12'h00C;
  localparam logic [11:0] PMT_OFF_MASK = 12'h010;
  // control field layout
  localparam int PMT_PRE_LSB = 0;
  localparam int PMT_RUN_BIT = 2;
  localparam int PMT_POST_LSB = 3;
  localparam logic [7:0] PMT_CTRL_WMASK = 8'h7F;
  // status bit of the period match flag
  localparam int PMT_FLAG_BIT = 3;
  localparam logic [7:0] PMT_STAT_WMASK = 8'h08;
  // prescale codes and divide counts
  localparam logic [1:0] PMT_PRE_DIV1 = 2'h0;
  localparam logic [1:0] PMT_PRE_DIV4 = 2'h1;
  localparam logic [3:0] PMT_PRE_LAST4 = 4'h3;
  localparam logic [3:0] PMT_PRE_LAST16 = 4'hF;
  // instruction clock is the system clock divided by four
  localparam logic [1:0] PMT_ICLK_LAST = 2'h3;
  localparam logic [7:0] PMT_RESET_BYTE = 8'h00;
  localparam logic [7:0] PMT_PERIOD_RESET = 8'hFF;
endpackage : pmt_pkg

// ===== sim/test_pmt_timer.sv
// testbench: apb register, interrupt and timing checks of the period match timer
`timescale 1ns/1ps
`default_nettype none
module test_pmt_timer;
  import pmt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd;
  logic [31:0] rv;
  logic rdy, err, pm, irq, ev;
  int failures = 0;
  int cmp_count = 0;
  int n, m, k, dv;
  // clock, 8 ns period
  always #4 clk = ~clk;
  pmt_timer dut (.i_mclk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(err), .o_period_match(pm), .o_irq(irq));
  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer: setup, access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (rdy !== 1'b1 && t < 50);
    if (t >= 50) failures++;
    rv = prd;
    ev = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rv, exp);
  endtask : rd
  // cycles until the next period match pulse, bounded
  task automatic wait_match();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pm !== 1'b1 && n < 5000);
  endtask : wait_match
  // verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // watchdog against a hung handshake or a silent timer
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    results();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(PMT_OFF_CONTROL, 32'h0000_0000);
    rd(PMT_OFF_COUNT, 32'h0000_0000);
    rd(PMT_OFF_PERIOD, 32'h0000_00FF);
    rd(PMT_OFF_STATUS, 32'h0000_0000);
    $display("test reset done");
    wr(PMT_OFF_PERIOD, 32'h0000_005A);
    rd(PMT_OFF_PERIOD, 32'h0000_005A);
    wr(PMT_OFF_CONTROL, 32'h0000_00FF);
    rd(PMT_OFF_CONTROL, 32'h0000_007F);
    wr(PMT_OFF_CONTROL, 32'h0000_0000);
    wr(PMT_OFF_COUNT, 32'h0000_0033);
    wr(PMT_OFF_CONTROL, 32'h0000_0001);
    rd(PMT_OFF_COUNT, 32'h0000_0033);
    apb(1'b1, 12'h020, 32'h0000_0001);
    check({31'h0, ev}, 32'h0000_0001);
    $display("test registers done");
    // match interval is 4 * prescale * (period + 1) clocks
    wr(PMT_OFF_PERIOD, 32'h0000_0001);
    for (int c = 0; c < 4; c++) begin
      dv = (c == 0) ? 1 : ((c == 1) ? 4 : 16);
      wr(PMT_OFF_CONTROL, 32'h0000_0004 | 32'(c));
      wait_match();
      wait_match();
      check(32'(n), 32'(8 * dv));
    end
    $display("test prescale done");
    // postscale 1:4 needs four matches before the flag and interrupt
    wr(PMT_OFF_CONTROL, 32'h0000_0000);
    wr(PMT_OFF_STATUS, 32'h0000_0008);
    wr(PMT_OFF_MASK, 32'h0000_0008);
    wr(PMT_OFF_CONTROL, 32'h0000_001C);
    m = 0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (pm === 1'b1) m++;
    end while (irq !== 1'b1 && k < 2000);
    check(32'(m), 32'h0000_0004);
    rd(PMT_OFF_STATUS, 32'h0000_0008);
    rd(PMT_OFF_MASK, 32'h0000_0008);
    wr(PMT_OFF_MASK, 32'h0000_0000);
    @(posedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    wr(PMT_OFF_CONTROL, 32'h0000_0000);
    wr(PMT_OFF_STATUS, 32'h0000_0008);
    rd(PMT_OFF_STATUS, 32'h0000_0000);
    $display("test interrupt done");
    results();
  end
endmodule : test_pmt_timer
`default_nettype wire
